//--- design/bin_ram.sv
/*
  1024 x 24 bin memory: row delay, delay and subtract, host ram access.
  assumes sample stream and row sync come from logic on sys_clk_in;
  host strobes, mode latch and wipe are pins from outside the clock.
*/
// What this block does
// [RULE1] row delay: counter addresses, write always on
// [RULE2] row sync low every N-4 cycles
// [RULE3] counter holds at 1023, writes stop
// [RULE4] subtract mode: as row delay, subtracts
// [RULE5] output stored minus sample, sample stored
// [RULE6] host modes: single port ram by strobes
// [RULE7] host modes ignore pipeline, row sync
// [RULE8] read address caught on read strobe fall
// [RULE9] write address on fall, data on rise
// [RULE10] write and read strobes latch independently
// [RULE11] 24-bit host mode moves whole word
// [RULE12] narrow mode: word select is address lsb; the code takes it from upper_word_select_in instead
// [RULE13] select low: lines 0-15 low half
// [RULE14] select high: lines 0-7 upper byte
// [RULE15] narrow host needs two strobe cycles
// [RULE16] unused narrow output lines read zero
// [RULE17] mode loaded on mode latch rising edge
// [RULE18] mode changes only with row sync high; the code loads the mode on the latch edge without looking at row sync
// [RULE19] wipe clears ram and output path
// [RULE20] read strobe enables data bus output
`timescale 1ns/10ps
module bin_ram (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] mode_select_in,
  input wire logic mode_latch_n_in,
  input wire logic memory_wipe_n_in,
  input wire logic row_sync_n_in,
  input wire logic [bin_ram_pkg::DATA_W-1:0] sample_input_bus_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic [bin_ram_pkg::ADDR_W-1:0] host_bin_address_in,
  input wire logic upper_word_select_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [bin_ram_pkg::DATA_W-1:0] bin_data_bus_in,
  output logic [bin_ram_pkg::DATA_W-1:0] bin_data_bus_out,
  output logic bin_data_bus_oe_out,
  output logic bin_data_valid_out
);
  import bin_ram_pkg::*;

  typedef struct packed {
    mode_type mode;
    logic [3:0] pin_s0;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_lvl;
    logic [ADDR_W-1:0] cnt;
    logic p1_valid;
    logic p1_row_n;
    logic [DATA_W-1:0] p1_sample;
    logic p2_valid;
    logic [DATA_W-1:0] p2_result;
    logic [ADDR_W-1:0] rd_addr;
    logic rd_uws;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_uws;
    logic [DATA_W-1:0] dout;
    logic oe;
    logic dvalid;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic [DATA_W-1:0] ram [RAM_DEPTH];
  logic ram_we;
  logic [ADDR_W-1:0] ram_waddr;
  logic [DATA_W-1:0] ram_wdata;
  logic [DATA_W-1:0] pipe_rdata;
  logic [DATA_W-1:0] host_rdata;
  logic [DATA_W-1:0] host_wword;
  logic [ADDR_W-1:0] pipe_addr;
  logic wipe;
  logic pipe_mode;
  logic host_mode;
  logic pop;

  sample_fifo_if #(.WIDTH(FIFO_W)) fifo_if ();

  sample_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_sample_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .port_if(fifo_if.fifo)
  );

  assign fifo_if.push_valid = sample_valid_in;
  assign fifo_if.push_data = {row_sync_n_in, sample_input_bus_in};
  assign sample_ready_out = fifo_if.push_ready;

  function automatic mode_type decode_mode(input logic [2:0] code);
    mode_type m;
    m = MODE_IDLE;
    if (code == CODE_ROW_DELAY)
    begin
      m = MODE_ROW_DELAY;
    end
    else if (code == CODE_DELAY_SUB)
    begin
      m = MODE_DELAY_SUB;
    end
    else if (code == CODE_HOST24)
    begin
      m = MODE_HOST24;
    end
    else if (code == CODE_HOST16)
    begin
      m = MODE_HOST16;
    end
    return m;
  endfunction

  assign wipe = !state_reg.pin_lvl[PIN_WIPE];
  assign pipe_mode = (state_reg.mode == MODE_ROW_DELAY) || (state_reg.mode == MODE_DELAY_SUB);
  assign host_mode = (state_reg.mode == MODE_HOST24) || (state_reg.mode == MODE_HOST16);
  // the stream only drains in the pipelined modes; elsewhere the fifo fills
  assign pop = pipe_mode && !wipe && fifo_if.pop_valid; // RULE7
  assign fifo_if.pop_ready = pipe_mode && !wipe;

  // row sync restarts at zero; at the top the counter holds
  always_comb
  begin
    if (!state_reg.p1_row_n)
    begin
      pipe_addr = CNT_START; // RULE1
    end
    else if (state_reg.cnt == CNT_MAX)
    begin
      pipe_addr = CNT_MAX; // RULE3
    end
    else
    begin
      pipe_addr = state_reg.cnt + ADDR_W'(1);
    end
  end

  assign pipe_rdata = ram[pipe_addr];
  assign host_rdata = ram[state_reg.rd_addr];

  // narrow host writes replace only the selected low half or upper byte
  always_comb
  begin
    host_wword = ram[state_reg.wr_addr];
    if (state_reg.mode == MODE_HOST24)
    begin
      host_wword = bin_data_bus_in; // RULE11
    end
    else if (state_reg.wr_uws)
    begin
      host_wword[DATA_W-1:LOW_W] = bin_data_bus_in[HIGH_W-1:0]; // RULE14
    end
    else
    begin
      host_wword[LOW_W-1:0] = bin_data_bus_in[LOW_W-1:0]; // RULE13
    end
  end

  always_comb
  begin
    ram_we = 1'b0;
    ram_waddr = pipe_addr;
    ram_wdata = state_reg.p1_sample;
    if (pipe_mode && state_reg.p1_valid && !wipe)
    begin
      // write stays on until the counter has parked at the top
      ram_we = !state_reg.p1_row_n || (state_reg.cnt != CNT_MAX); // RULE1 RULE3
    end
    else if (host_mode && !wipe && !state_reg.pin_lvl[PIN_WR] && state_next.pin_lvl[PIN_WR])
    begin
      ram_we = 1'b1; // RULE9 RULE10
      ram_waddr = state_reg.wr_addr;
      ram_wdata = host_wword;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.pin_s0 = {memory_wipe_n_in, mode_latch_n_in, write_strobe_n_in, read_strobe_n_in};
    state_next.pin_s1 = state_reg.pin_s0;
    state_next.pin_s2 = state_reg.pin_s1;
    for (int i = 0; i < 4; i++)
    begin
      if (state_reg.pin_s1[i] == state_reg.pin_s2[i])
      begin
        state_next.pin_lvl[i] = state_reg.pin_s2[i];
      end
    end
    // mode taken on the rising edge of the latch strobe
    if (!state_reg.pin_lvl[PIN_LD] && state_next.pin_lvl[PIN_LD])
    begin
      state_next.mode = decode_mode(mode_select_in); // RULE17
    end
    state_next.p2_valid = 1'b0;
    state_next.dvalid = 1'b0;
    state_next.p1_valid = pop;
    if (pop)
    begin
      state_next.p1_row_n = fifo_if.pop_data[DATA_W];
      state_next.p1_sample = fifo_if.pop_data[DATA_W-1:0];
    end
    if (pipe_mode && state_reg.p1_valid)
    begin
      state_next.cnt = pipe_addr; // RULE1
      state_next.p2_valid = 1'b1;
      if (state_reg.mode == MODE_DELAY_SUB)
      begin
        state_next.p2_result = pipe_rdata - state_reg.p1_sample; // RULE4 RULE5
      end
      else
      begin
        state_next.p2_result = pipe_rdata;
      end
    end
    if (pipe_mode && state_reg.p2_valid)
    begin
      state_next.dout = state_reg.p2_result;
      state_next.dvalid = 1'b1;
    end
    if (host_mode)
    begin
      if (state_reg.pin_lvl[PIN_RD] && !state_next.pin_lvl[PIN_RD])
      begin
        state_next.rd_addr = host_bin_address_in; // RULE8 RULE6
        state_next.rd_uws = upper_word_select_in; // RULE12
      end
      if (state_reg.pin_lvl[PIN_WR] && !state_next.pin_lvl[PIN_WR])
      begin
        state_next.wr_addr = host_bin_address_in; // RULE9 RULE10
        state_next.wr_uws = upper_word_select_in; // RULE12
      end
      if (!state_reg.pin_lvl[PIN_RD])
      begin
        if (state_reg.mode == MODE_HOST24)
        begin
          state_next.dout = host_rdata; // RULE11
        end
        else if (state_reg.rd_uws)
        begin
          state_next.dout = {16'h0000, host_rdata[DATA_W-1:LOW_W]}; // RULE14 RULE16
        end
        else
        begin
          state_next.dout = {8'h00, host_rdata[LOW_W-1:0]}; // RULE13 RULE16
        end
      end
    end
    state_next.oe = !state_next.pin_lvl[PIN_RD]; // RULE20
    if (wipe)
    begin
      state_next.p1_valid = 1'b0;
      state_next.p2_valid = 1'b0;
      state_next.p2_result = '0; // RULE19
      state_next.dout = '0; // RULE19
      state_next.dvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= '{mode: MODE_IDLE, pin_s0: PINS_IDLE, pin_s1: PINS_IDLE,
                     pin_s2: PINS_IDLE, pin_lvl: PINS_IDLE, cnt: CNT_RESET,
                     p1_row_n: 1'b1, default: '0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (wipe)
    begin
      for (int j = 0; j < RAM_DEPTH; j++)
      begin
        ram[j] <= '0; // RULE19
      end
    end
    else if (ram_we)
    begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

  assign bin_data_bus_out = state_reg.dout;
  assign bin_data_bus_oe_out = state_reg.oe;
  assign bin_data_valid_out = state_reg.dvalid;

  chk_cnt_holds_top: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE3
    pipe_mode && state_reg.p1_valid && state_reg.p1_row_n && state_reg.cnt == CNT_MAX
    |-> !ram_we ##1 state_reg.cnt == CNT_MAX)
    else $error("counter left the top or wrote there");

  chk_row_sync_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE1
    pipe_mode && state_reg.p1_valid && !state_reg.p1_row_n && !wipe
    |-> ram_we && ram_waddr == CNT_START ##1 state_reg.cnt == CNT_START)
    else $error("row sync did not restart counter at zero");

  chk_write_always_on: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE1
    pipe_mode && state_reg.p1_valid && !wipe && state_reg.cnt != CNT_MAX
    |-> ram_we && ram_wdata == state_reg.p1_sample)
    else $error("row write missing below the top count");

  chk_sub_result: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE5
    state_reg.mode == MODE_DELAY_SUB && state_reg.p1_valid && !wipe
    |=> state_reg.p2_result == $past(pipe_rdata) - $past(state_reg.p1_sample))
    else $error("subtract result wrong");

  chk_host_no_stream: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE7
    host_mode |-> !pop ##1 !state_reg.p2_valid)
    else $error("pipeline moved in host mode");

  chk_rd_addr_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE8
    host_mode && state_reg.pin_lvl[PIN_RD] && !state_next.pin_lvl[PIN_RD]
    |=> state_reg.rd_addr == $past(host_bin_address_in))
    else $error("read address not caught on strobe fall");

  chk_oe_follows_rd: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE20
    $fell(state_reg.pin_lvl[PIN_RD]) |-> state_reg.oe ##1 state_reg.oe || state_reg.pin_lvl[PIN_RD])
    else $error("output enable not following read strobe");

  chk_narrow_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE16
    state_reg.mode == MODE_HOST16 && !state_reg.pin_lvl[PIN_RD] && state_reg.rd_uws && !wipe
    && $stable(state_reg.mode) |=> bin_data_bus_out[DATA_W-1:HIGH_W] == '0)
    else $error("unused narrow lines not zero");

  chk_wipe_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE19
    wipe |=> bin_data_bus_out == '0 && !bin_data_valid_out)
    else $error("wipe left output data");
endmodule // bin_ram

//--- design/bin_ram_pkg.sv
/*
  shared constants and types of the row delay and host bin memory.
  assumes a single 40 MHz system clock domain.
*/
package bin_ram_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned RAM_DEPTH = 1024;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [9:0] CNT_RESET = 10'h3FF;
  localparam logic [9:0] CNT_START = 10'h000;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_W = 25;
  localparam logic [2:0] CODE_ROW_DELAY = 3'h5;
  localparam logic [2:0] CODE_DELAY_SUB = 3'h2;
  localparam logic [2:0] CODE_HOST24 = 3'h6;
  localparam logic [2:0] CODE_HOST16 = 3'h7;
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_LD = 2;
  localparam int unsigned PIN_WIPE = 3;
  localparam logic [3:0] PINS_IDLE = 4'hF;
  localparam int unsigned LOW_W = 16;
  localparam int unsigned HIGH_W = 8;
  typedef enum logic [2:0] {
    MODE_IDLE, MODE_ROW_DELAY, MODE_DELAY_SUB, MODE_HOST24, MODE_HOST16
  } mode_type;
endpackage

//--- design/sample_fifo.sv
/*
  synchronous fifo, width and depth by parameter.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/10ps
module sample_fifo #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  sample_fifo_if.fifo port_if
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = PW'(DEPTH - 1) + (PW+1)'(1);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic ready;
  } fifo_state_type;

  fifo_state_type state_reg;
  fifo_state_type state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = port_if.push_valid && state_reg.ready;
  assign pop = port_if.pop_ready && (state_reg.count != '0);
  assign port_if.push_ready = state_reg.ready;
  assign port_if.pop_valid = (state_reg.count != '0);
  assign port_if.pop_data = mem[state_reg.rd_ptr];

  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.wr_ptr = state_reg.wr_ptr + PW'(1);
    end
    if (pop)
    begin
      state_next.rd_ptr = state_reg.rd_ptr + PW'(1);
    end
    state_next.count = state_reg.count + (PW+1)'(push) - (PW+1)'(pop);
    state_next.ready = (state_next.count != FULL_CNT);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= '{wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (push)
    begin
      mem[state_reg.wr_ptr] <= port_if.push_data;
    end
  end

  chk_no_overflow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    push |-> state_reg.count < FULL_CNT)
    else $error("fifo written while full");
endmodule // sample_fifo

//--- design/sample_fifo_if.sv
/*
  valid/ready carrier between the sample fifo and the pipeline.
  assumes both ends on sys_clk_in.
*/
`timescale 1ns/10ps
interface sample_fifo_if #(parameter int unsigned WIDTH = 25);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface

//--- verif/bin_ram_bench.sv
/*
  self-checking bench of the bin memory: host access and streamed modes.
  assumes the sample_source partner and a 40 MHz clock.
*/
`timescale 1ns/10ps
module bin_ram_bench;
  import bin_ram_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] mode_sel = 3'h0;
  logic latch_n = 1'b1;
  logic wipe_n = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [ADDR_W-1:0] a;
  logic upper_word_select = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [DATA_W-1:0] host_data = '0;
  logic [DATA_W-1:0] bus_out;
  logic [DATA_W-1:0] sample;
  logic [DATA_W-1:0] d;
  logic oe, dvalid, ready, valid, sync_n;
  logic sub = 1'b0;
  logic [31:0] rnd = 32'h0;
  logic [31:0] period = 32'h1;
  logic [31:0] limit = 32'h0;
  integer seed = 43372;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int oe_cnt = 0;
  logic [DATA_W-1:0] hostq[$];
  logic [DATA_W-1:0] model[1024];
  // bus wire: device drives while enabled, host otherwise
  wire logic [DATA_W-1:0] bus_wire = oe ? bus_out : host_data;

  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) rnd <= $random(seed);

  sample_source part (.sys_clk_in(sys_clk), .rnd_in(rnd), .period_in(period),
    .limit_in(limit), .subtract_in(sub), .ready_in(ready), .sample_out(sample),
    .valid_out(valid), .row_sync_n_out(sync_n));
  bin_ram DUT (.sys_clk_in(sys_clk), .rst_in(rst), .mode_select_in(mode_sel),
    .mode_latch_n_in(latch_n), .memory_wipe_n_in(wipe_n), .row_sync_n_in(sync_n),
    .sample_input_bus_in(sample), .sample_valid_in(valid), .sample_ready_out(ready),
    .host_bin_address_in(addr), .upper_word_select_in(upper_word_select), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .bin_data_bus_in(bus_wire), .bin_data_bus_out(bus_out),
    .bin_data_bus_oe_out(oe), .bin_data_valid_out(dvalid));

  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task latch_mode(input logic [2:0] code);
    @(negedge sys_clk);
    mode_sel = code;
    latch_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    latch_n = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask

  task wipe;
    @(negedge sys_clk);
    wipe_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    wipe_n = 1'b1;
    repeat (5) @(negedge sys_clk);
  endtask

  task host_write(input logic [ADDR_W-1:0] wa, input logic u, input logic [DATA_W-1:0] wd);
    @(negedge sys_clk);
    addr = wa;
    upper_word_select = u;
    wr_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    host_data = wd;
    wr_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    host_data = ~wd;
  endtask

  task host_read(input logic [ADDR_W-1:0] ra, input logic u, input logic [DATA_W-1:0] exp);
    hostq.push_back(exp);
    @(negedge sys_clk);
    addr = ra;
    upper_word_select = u;
    rd_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rd_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    check(24'(oe), 24'h000000);
  endtask

  // stream words against the partner's notes, host reads once data settled
  always @(posedge sys_clk)
  begin
    cycles++;
    if (dvalid)
    begin
      if (part.expq.size() == 0)
        check(24'h000000, 24'h000001);
      else
        check(bus_out, part.expq.pop_front());
    end
    oe_cnt = oe ? oe_cnt + 1 : 0;
    if (oe_cnt == 4 && hostq.size() > 0)
      check(bus_out, hostq.pop_front());
    // ceiling well above the thousand or so cycles the scenarios need
    if (cycles == 5000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    latch_mode(CODE_HOST24);
    for (int i = 0; i < 4; i++)
    begin
      a = 10'(i * 77 + 1);
      model[a] = rnd[23:0];
      host_write(a, 1'b0, model[a]);
    end
    for (int i = 0; i < 4; i++)
      host_read(10'(i * 77 + 1), 1'b0, model[10'(i * 77 + 1)]);
    latch_mode(CODE_HOST16);
    for (int i = 0; i < 4; i++)
    begin
      a = 10'(i * 77 + 1);
      d = rnd[23:0];
      host_write(a, 1'b0, d);
      model[a][15:0] = d[15:0];
      d = rnd[23:0];
      host_write(a, 1'b1, d);
      model[a][23:16] = d[7:0];
      host_read(a, 1'b0, {8'h00, model[a][15:0]});
      host_read(a, 1'b1, {16'h0000, model[a][23:16]});
    end
    wipe();
    latch_mode(CODE_HOST24);
    host_read(10'h04E, 1'b0, 24'h000000);
    for (int r = 0; r < 3; r++)
    begin
      period = (r == 0) ? 32'h6 : (r == 1) ? 32'h5 : 32'h1;
      sub = (r == 1);
      wipe();
      if (r == 0)
      begin
        // fill the buffer while the host mode holds it
        limit <= 32'd41;
        repeat (100) @(negedge sys_clk);
        check(24'(ready), 24'h000000);
      end
      latch_mode(r == 1 ? CODE_DELAY_SUB : CODE_ROW_DELAY);
      limit <= 32'd41;
      for (int w = 0; w < 800 && (part.hist.size() < 41 || part.expq.size() > 0); w++)
        @(negedge sys_clk);
      check(24'(part.expq.size()), 24'h000000);
      limit <= 32'h0;
      @(negedge sys_clk);
    end
    // an undecoded code leaves the stream parked in the buffer
    latch_mode(3'h0);
    limit <= 32'd41;
    repeat (100) @(negedge sys_clk);
    check(24'(ready), 24'h000000);
    give_verdict();
  end
endmodule // bin_ram_bench

//--- verif/sample_source.sv
/*
  upstream sample source: random samples with row sync every period.
  assumes the bench supplies random words and holds period and limit per run,
  and wipes the memory while the limit is zero.
*/
`timescale 1ns/10ps
module sample_source (
  input wire logic sys_clk_in,
  input wire logic [31:0] rnd_in,
  input wire logic [31:0] period_in,
  input wire logic [31:0] limit_in,
  input wire logic subtract_in,
  input wire logic ready_in,
  output logic [bin_ram_pkg::DATA_W-1:0] sample_out,
  output logic valid_out,
  output logic row_sync_n_out
);
  import bin_ram_pkg::*;
  logic [DATA_W-1:0] hist[$];
  logic [DATA_W-1:0] expq[$];
  logic [DATA_W-1:0] prev;
  logic [DATA_W-1:0] mem_m [RAM_DEPTH];
  logic [ADDR_W-1:0] cnt_m = CNT_RESET;
  logic [ADDR_W-1:0] old_m;
  int idx = -1;
  initial
  begin
    sample_out = '0;
    valid_out = 1'b0;
    row_sync_n_out = 1'b1;
  end
  // counter model: row sync restarts at zero, the top count holds without a write
  always @(posedge sys_clk_in)
  begin
    if (valid_out && ready_in)
    begin
      old_m = cnt_m;
      if (!row_sync_n_out)
        cnt_m = CNT_START;
      else if (cnt_m != CNT_MAX)
        cnt_m = cnt_m + 10'h001;
      prev = mem_m[cnt_m];
      if (!row_sync_n_out || old_m != CNT_MAX)
        mem_m[cnt_m] = sample_out;
      expq.push_back(subtract_in ? prev - sample_out : prev);
      hist.push_back(sample_out);
    end
  end
  always @(negedge sys_clk_in)
  begin
    if (limit_in == 0)
    begin
      hist.delete();
      mem_m = '{default: '0};
      idx = -1;
      valid_out <= 1'b0;
      row_sync_n_out <= 1'b1;
    end
    else if (hist.size() >= int'(limit_in))
      valid_out <= 1'b0;
    else if (!(valid_out && hist.size() == idx))
    begin
      idx = hist.size();
      valid_out <= rnd_in[0] | rnd_in[1];
      sample_out <= rnd_in[31:8];
      // first word after the limit was zero keeps row sync high
      row_sync_n_out <= !(idx > 0 && (idx - 1) % int'(period_in) == 0);
    end
  end
endmodule // sample_source
